//--- inc/ums_map.vh
`ifndef UMS_MAP_VH
`define UMS_MAP_VH

// ************************************************************
// Register offsets (byte addresses)
// ************************************************************
`define UMS_OFF_STAT1  12'h000
`define UMS_OFF_EN1    12'h004
`define UMS_OFF_STAT2  12'h008
`define UMS_OFF_EN2    12'h00c
`define UMS_OFF_ISTAT  12'h010
`define UMS_OFF_IMASK  12'h014

// ************************************************************
// Modem status field positions
// ************************************************************
`define UMS_BIT_CTS_DELTA  0
`define UMS_BIT_DSR_DELTA  1
`define UMS_BIT_RING_RISE  2
`define UMS_BIT_CD_DELTA   3
`define UMS_BIT_CTS        4
`define UMS_BIT_DSR        5
`define UMS_BIT_RING       6
`define UMS_BIT_CD         7
`define UMS_EN_MODEM       3

// ************************************************************
// Reset values
// ************************************************************
`define UMS_EN_RESET    8'h00
`define UMS_MASK_RESET  2'h0

`endif

//--- logic/ums_port.v
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// One serial port's modem status logic
// ************************************************************
module ums_port (
  input  wire       pclk,
  input  wire       presetn,
  input  wire [3:0] lines_n,
  input  wire       status_read,
  input  wire       modem_int_en,
  output wire [7:0] status,
  output reg        modem_int
);
  reg  [3:0] sync1;
  reg  [3:0] sync2;
  reg  [3:0] prev;
  reg  [3:0] delta;
  wire [3:0] level;
  wire [3:0] rise_n;
  wire       change;

  // Lines order: 0 cts, 1 dsr, 2 ri, 3 dcd
  assign level  = ~sync2;
  assign rise_n = sync2 & ~prev;
  assign change = |(sync2 ^ prev);

  // Two-stage synchroniser and history
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= 4'hf;
      sync2 <= 4'hf;
      prev  <= 4'hf;
    end else begin
      sync1 <= lines_n;
      sync2 <= sync1;
      prev  <= sync2;
    end
  end

  // Delta bits: low-to-high edge on pin, set beats read clear
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_delta
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          delta[i] <= 1'b0;
        end else if (rise_n[i]) begin
          delta[i] <= 1'b1;
        end else if (status_read) begin
          delta[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // Modem status interrupt on any change
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      modem_int <= 1'b0;
    end else if (change && modem_int_en) begin
      modem_int <= 1'b1;
    end else if (status_read || !modem_int_en) begin
      modem_int <= 1'b0;
    end
  end

  assign status = {level[3], level[2], level[1], level[0],
                   delta[3], delta[2], delta[1], delta[0]};
endmodule

`default_nettype wire

//--- logic/ums_top.v
// Behaviour
// - Each of the two ports has its own active-low dsr, carrier detect and ring inputs.
// - Status bit 5 reads the complement of the data set ready input.
// - Status bit 1 sets when data set ready rose low-to-high since the last status read.
// - Status bit 7 reads the complement of the carrier detect input.
// - Status bit 3 sets when carrier detect rose low-to-high since the last status read.
// - Status bit 6 reads the complement of the ring indicator input.
// - Status bit 2 sets when ring indicator rose low-to-high since the last status read.
// - With enable bit 3 set, any change on dsr, carrier detect or ring raises the interrupt.
// - Status bit 4 reads complemented clear-to-send and bit 0 marks its low-to-high edge.
// - Clear-to-send is status only and raises the modem interrupt, nothing else.
`timescale 1ns/1ps
`default_nettype none
`include "ums_map.vh"

module ums_top (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        primary_clear_to_send_n,
  input  wire        primary_data_set_ready_n,
  input  wire        primary_ring_indicator_n,
  input  wire        primary_carrier_detect_n,
  input  wire        secondary_clear_to_send_n,
  input  wire        secondary_data_set_ready_n,
  input  wire        secondary_ring_indicator_n,
  input  wire        secondary_carrier_detect_n,
  output reg         primary_irq,
  output reg         secondary_irq,
  output reg         irq
);
  reg  [7:0] interrupt_enable_register [0:1];
  reg  [1:0] int_status;
  reg  [1:0] int_mask;
  wire [7:0] modem_status_register [0:1];
  wire [1:0] port_int;
  wire [1:0] status_read;
  wire [3:0] lines_n [0:1];
  wire       access;
  wire       rd;
  wire       wr;
  reg  [31:0] next_prdata;
  reg         next_err;

  // ************************************************************
  // APB access decode
  // ************************************************************
  assign access = psel & penable & pready;
  assign rd     = access & ~pwrite;
  assign wr     = access & pwrite;
  assign status_read[0] = rd & (paddr == `UMS_OFF_STAT1);
  assign status_read[1] = rd & (paddr == `UMS_OFF_STAT2);

  // ************************************************************
  // Per-port modem status
  // ************************************************************
  assign lines_n[0] = {primary_carrier_detect_n, primary_ring_indicator_n,
                       primary_data_set_ready_n, primary_clear_to_send_n};
  assign lines_n[1] = {secondary_carrier_detect_n, secondary_ring_indicator_n,
                       secondary_data_set_ready_n, secondary_clear_to_send_n};

  // Status bits 7..4 levels, 3..0 deltas; cts affects status and the modem interrupt
  genvar p;
  generate
    for (p = 0; p < 2; p = p + 1) begin : g_port
      ums_port u_port (
        .pclk         (pclk),
        .presetn      (presetn),
        .lines_n      (lines_n[p]),
        .status_read  (status_read[p]),
        .modem_int_en (interrupt_enable_register[p][`UMS_EN_MODEM]),
        .status       (modem_status_register[p]),
        .modem_int    (port_int[p])
      );
    end
  endgenerate

  // ************************************************************
  // Registers
  // ************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_enable_register[0] <= `UMS_EN_RESET;
      interrupt_enable_register[1] <= `UMS_EN_RESET;
      int_mask                     <= `UMS_MASK_RESET;
    end else if (wr) begin
      if (paddr == `UMS_OFF_EN1) begin
        interrupt_enable_register[0] <= pwdata[7:0];
      end else if (paddr == `UMS_OFF_EN2) begin
        interrupt_enable_register[1] <= pwdata[7:0];
      end else if (paddr == `UMS_OFF_IMASK) begin
        int_mask <= pwdata[1:0];
      end
    end
  end

  // Sticky event bits, set beats read clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_status <= 2'h0;
    end else if (rd && paddr == `UMS_OFF_ISTAT) begin
      int_status <= port_int;
    end else begin
      int_status <= int_status | port_int;
    end
  end

  // ************************************************************
  // Read mux and answer
  // ************************************************************
  always @* begin
    next_prdata = 32'h0000_0000;
    next_err    = 1'b0;
    if (paddr == `UMS_OFF_STAT1) begin
      next_prdata = {24'h00_0000, modem_status_register[0]};
    end else if (paddr == `UMS_OFF_EN1) begin
      next_prdata = {24'h00_0000, interrupt_enable_register[0]};
    end else if (paddr == `UMS_OFF_STAT2) begin
      next_prdata = {24'h00_0000, modem_status_register[1]};
    end else if (paddr == `UMS_OFF_EN2) begin
      next_prdata = {24'h00_0000, interrupt_enable_register[1]};
    end else if (paddr == `UMS_OFF_ISTAT) begin
      next_prdata = {30'h0000_0000, int_status};
    end else if (paddr == `UMS_OFF_IMASK) begin
      next_prdata = {30'h0000_0000, int_mask};
    end else begin
      next_err = 1'b1;
    end
  end

  // No wait state: ready rises at the setup cycle's closing edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (psel && !penable) begin
      pready  <= 1'b1;
      pslverr <= next_err;
      prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Interrupt outputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      primary_irq   <= 1'b0;
      secondary_irq <= 1'b0;
      irq           <= 1'b0;
    end else begin
      primary_irq   <= port_int[0];
      secondary_irq <= port_int[1];
      irq           <= |(int_status & int_mask);
    end
  end
endmodule

`default_nettype wire

//--- verification/test_ums_top.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// Testbench
// ****************
module test_ums_top;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd;
  logic [7:0]  want = 8'hff, old;
  logic [1:0]  en, mask, pend;
  wire  [7:0]  pins_n;
  wire  [31:0] prdata;
  wire         pready, pslverr, primary_irq, secondary_irq, irq;
  int          failures = 0, comparisons = 0, k;
  ums_modem i_ums_modem (.pclk(pclk), .want(want), .pins_n(pins_n));
  ums_top i_ums_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .primary_clear_to_send_n(pins_n[0]),
    .primary_data_set_ready_n(pins_n[1]), .primary_ring_indicator_n(pins_n[2]),
    .primary_carrier_detect_n(pins_n[3]), .secondary_clear_to_send_n(pins_n[4]),
    .secondary_data_set_ready_n(pins_n[5]), .secondary_ring_indicator_n(pins_n[6]),
    .secondary_carrier_detect_n(pins_n[7]), .primary_irq(primary_irq),
    .secondary_irq(secondary_irq), .irq(irq));
  function logic [31:0] stat(input logic [3:0] o, input logic [3:0] n);
    return {24'h0, ~n, ~o & n};
  endfunction
  task test_done();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  initial forever #20 pclk = ~pclk;
  initial begin
    #1000000;
    failures++;
    test_done();
  end
  initial begin
    k = $urandom(32'h4744642f);
    repeat (2) @(posedge pclk);
    presetn <= 1;
    apb(0, 12'h004, 0);
    check(rd, 32'h0);
    apb(0, 12'h014, 0);
    check(rd, 32'h0);
    apb(0, 12'h020, 0);
    check(32'(err), 32'h1);
    for (k = 0; k < 40; k++) begin
      en = 2'($urandom);
      mask = 2'($urandom);
      apb(1, 12'h004, {28'h0, en[0], 3'h0});
      apb(1, 12'h00c, {28'h0, en[1], 3'h0});
      apb(1, 12'h014, {30'h0, mask});
      apb(0, 12'h010, 0);
      old = want;
      want <= k == 0 ? 8'h00 : k == 1 ? 8'hff : 8'($urandom);
      repeat (7) @(posedge pclk);
      pend = {want[7:4] != old[7:4], want[3:0] != old[3:0]} & en;
      check(32'({secondary_irq, primary_irq}), 32'(pend));
      check(32'(irq), 32'(|(pend & mask)));
      apb(0, 12'h010, 0);
      check(rd, 32'(pend));
      apb(0, 12'h000, 0);
      check(rd, stat(old[3:0], want[3:0]));
      apb(0, 12'h008, 0);
      check(rd, stat(old[7:4], want[7:4]));
      apb(0, 12'h010, 0);
      check(rd, 32'(pend));
      apb(0, 12'h000, 0);
      check(rd, stat(want[3:0], want[3:0]));
      @(posedge pclk);
      check(32'({secondary_irq, primary_irq, irq}), 32'h0);
    end
    test_done();
  end
endmodule
bind ums_top ums_chk i_ums_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .pp_n({primary_carrier_detect_n, primary_ring_indicator_n,
  primary_data_set_ready_n, primary_clear_to_send_n}), .primary_irq(primary_irq));
`default_nettype wire

//--- verification/ums_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// Port checker
// ****************
module ums_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [3:0]  pp_n,
  input wire logic        primary_irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire rd0 = psel && penable && pready && !pwrite && paddr == 12'h000;
  ready_next_a: assert property (psel && !penable |=> pready) else $error("late pready");
  ready_pulse_a: assert property (pready |=> !pready) else $error("long pready");
  err_ready_a: assert property (pslverr |-> pready) else $error("stray pslverr");
  err_data_a: assert property (pslverr |-> prdata == 32'h0) else $error("error data");
  unmapped_err_a: assert property (pready && paddr > 12'h014 |-> pslverr)
    else $error("no pslverr");
  upper_zero_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper bits set");
  level_bits_a: assert property ($stable(pp_n)[*5] ##0 rd0 |-> prdata[7:4] == ~pp_n)
    else $error("status levels wrong");
  read_clear_a: assert property ($stable(pp_n)[*6] ##0 rd0 |-> ##2 !primary_irq)
    else $error("interrupt kept");
  cover property (rd0);
  cover property ($rose(primary_irq));
  cover property (pslverr);
endmodule
`default_nettype wire

//--- verification/ums_modem.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// Modem pin driver
// ****************
module ums_modem (
  input  wire logic       pclk,
  input  wire logic [7:0] want,
  output var  logic [7:0] pins_n
);
  initial pins_n = 8'hff;
  always @(posedge pclk) begin
    pins_n <= want;
  end
endmodule
`default_nettype wire
